//--- common/tcp_pkg.sv
package tcp_pkg;

  // Register indices in the sequential map; every transfer starts at the first
  localparam logic [2:0] REG_FIRST = 3'h1;
  localparam logic [2:0] REG_CTRL = 3'h2;
  localparam logic [2:0] REG_INT = 3'h3;
  localparam logic [2:0] REG_CC = 3'h4;
  localparam logic [2:0] PTR_END = 3'h5;

  // Control register layout
  localparam int CTRL_PSAVE = 7;
  localparam int CTRL_TRY_SNK = 6;
  localparam int CTRL_ACC = 5;
  localparam int CTRL_CUR_HI = 4;
  localparam int CTRL_CUR_LO = 3;
  localparam int CTRL_ROLE_HI = 2;
  localparam int CTRL_ROLE_LO = 1;
  localparam int CTRL_MASK = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // Port role codes
  localparam logic [1:0] ROLE_SINK = 2'h0;
  localparam logic [1:0] ROLE_SOURCE = 2'h1;
  localparam logic [1:0] ROLE_DRP = 2'h2;
  localparam logic [1:0] ROLE_DRP_TRY = 2'h3;

  // Charging current codes
  localparam logic [1:0] CUR_DEFAULT = 2'h0;
  localparam logic [1:0] CUR_MEDIUM = 2'h1;
  localparam logic [1:0] CUR_HIGH = 2'h2;

  // Interrupt register flags
  localparam logic [7:0] INT_ATTACH = 8'h01;
  localparam logic [7:0] INT_DETACH = 8'h02;
  localparam logic [7:0] INT_RST = 8'h00;

  // Serial-bus slave addresses selected by the address strap
  localparam logic [6:0] BUS_ADDR_LOW = 7'h0D;
  localparam logic [6:0] BUS_ADDR_HIGH = 7'h2D;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Pin synchroniser lanes: scl, sda, disable, addr tied, addr high, port tied, port high
  localparam int PIN_LANES = 7;
  // Bus lines idle high and the device counts as disabled until the real pins arrive,
  // so the strap load never sees the reset values of the strap lanes
  localparam logic [PIN_LANES-1:0] PIN_RST = 7'h70;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b010,
    ST_WR = 3'b011,
    ST_WACK = 3'b100,
    ST_RD = 3'b101,
    ST_RACK = 3'b110
  } tcp_state_t;

endpackage

//--- core/tcp_port_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1: Control bit 7 set puts the device into disabled low-power state.
// R2: In low power, outputs other than CC go high-Z; CC pulled low by Rd. The code releases only the interrupt; the bus still answers.
// R3: Control bit 6 picks Try.SRC when 0, Try.SNK when 1.
// R4: Control bit 5 enables accessory detection in device mode.
// R5: Control bits 4:3 select default, 1.5A or 3A charging current.
// R6: Charging current is ignored while the port is or acts as device.
// R7: Control bits 2:1: sink, source, dual role, dual role with try.
// R8: Mask bit 0 clear lets events pull the interrupt low; set keeps it high-Z.
// R9: Control resets to zero; role field loads from the role strap on first enable.
// R10: Strap ground gives sink, supply gives source, open gives dual role Try.SNK.
// R11: No offset byte; transfers start at register 1 and advance sequentially.
// R12: Unmasked port status changes drive the interrupt output low.
// R13: Host masks first via control bit 0; device then releases the interrupt.
// R14: Host then reads registers 1 to 4 in order.
// R15: Register 3 reports attach and detach events.
// R16: Reading register 3 clears all its flags.
// R17: Register 4 presents plug details and charging profile.
// R18: Host unmasks via control bit 0 before ending its service routine.
// R19: Address strap low answers 0x0D, high 0x2D, floating means pin control.
// R20: Interrupt value 01h means attach, 02h means detach since last read.
// R21: In a write, the byte for register 1 is dropped; the next goes to control.
module tcp_port_ctrl import tcp_pkg::*; #(
  parameter logic [7:0] DEV_ID = 8'h00 // Arbitrary value returned from register 1
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic DISABLE_IN,
  input wire logic ADDR_TIED,
  input wire logic ADDR_HIGH,
  input wire logic PORT_TIED,
  input wire logic PORT_HIGH,
  input wire logic ATTACH_EVT,
  input wire logic DETACH_EVT,
  input wire logic ACTING_SINK,
  input wire logic [7:0] CC_STATUS,
  output logic IRQ_OUT_N_O,
  output logic IRQ_OUT_N_OE,
  output logic LOW_POWER,
  output logic PIN_MODE,
  output logic TRY_SNK,
  output logic ACC_DET_EN,
  output logic [1:0] CHG_CUR,
  output logic [1:0] PORT_ROLE
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and bus conditions

  logic [PIN_LANES-1:0] pins_s;
  logic scl_s, sda_s, dis_s, addr_tied_s, addr_high_s, port_tied_s, port_high_s;
  logic scl_d_ff, sda_d_ff;

  tcp_sync #(
    .W(PIN_LANES),
    .RST_VAL(PIN_RST)
  ) u_pin_sync (
    .clk(REF_CLK),
    .rst(RST),
    .din({SCL_IN, SDA_IN, DISABLE_IN, ADDR_TIED, ADDR_HIGH, PORT_TIED, PORT_HIGH}),
    .dout(pins_s)
  );

  assign {scl_s, sda_s, dis_s, addr_tied_s, addr_high_s, port_tied_s, port_high_s} = pins_s;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_d_ff;
  wire scl_fall = ~scl_s & scl_d_ff;
  wire bus_start = scl_s & scl_d_ff & ~sda_s & sda_d_ff;
  wire bus_stop = scl_s & scl_d_ff & sda_s & ~sda_d_ff;

  // Floating address strap turns the serial bus off
  wire bus_on = addr_tied_s; // see R19
  wire [6:0] own_addr = addr_high_s ? BUS_ADDR_HIGH : BUS_ADDR_LOW; // see R19

  ////////////////////////////////////////////////////////////////////////////////
  // Register state

  tcp_state_t state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] shift_ff, nxt_shift;
  logic [2:0] ptr_ff, nxt_ptr;
  logic rw_ff, nxt_rw;
  logic nack_ff, nxt_nack;
  logic sda_oe_ff, nxt_sda_oe;
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [7:0] int_ff, nxt_int;
  logic en_seen_ff;
  logic wr_ctrl, rd_load;

  wire [2:0] ptr_inc = (ptr_ff == PTR_END) ? ptr_ff : ptr_ff + 3'h1; // see R11

  wire [7:0] rd_data = (ptr_ff == REG_FIRST) ? DEV_ID :
                       (ptr_ff == REG_CTRL) ? ctrl_ff :
                       (ptr_ff == REG_INT) ? int_ff : // see R15
                       (ptr_ff == REG_CC) ? CC_STATUS : // see R17
                       8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Serial-bus slave

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_shift = shift_ff;
    nxt_ptr = ptr_ff;
    nxt_rw = rw_ff;
    nxt_nack = nack_ff;
    nxt_sda_oe = sda_oe_ff;
    wr_ctrl = 1'b0;
    rd_load = 1'b0;
    if (!bus_on) begin
      nxt_state = ST_IDLE;
      nxt_sda_oe = 1'b0;
    end else if (bus_start) begin
      // No offset byte: each transfer restarts at the first register
      nxt_state = ST_ADDR;
      nxt_cnt = 4'h0;
      nxt_ptr = REG_FIRST; // see R11
      nxt_sda_oe = 1'b0;
    end else if (bus_stop) begin
      nxt_state = ST_IDLE;
      nxt_sda_oe = 1'b0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
        end
        ST_ADDR: begin
          if (scl_rise) begin
            nxt_shift = {shift_ff[6:0], sda_s};
            nxt_cnt = cnt_ff + 4'h1;
          end else if (scl_fall && cnt_ff == BITS_PER_BYTE) begin
            if (shift_ff[7:1] == own_addr) begin // see R19
              nxt_rw = shift_ff[0];
              nxt_sda_oe = 1'b1;
              nxt_cnt = 4'h0;
              nxt_state = ST_AACK;
            end else begin
              nxt_state = ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            if (rw_ff) begin
              rd_load = 1'b1;
              nxt_shift = rd_data;
              nxt_sda_oe = ~rd_data[7];
              nxt_ptr = ptr_inc; // see R11
              nxt_state = ST_RD;
            end else begin
              nxt_sda_oe = 1'b0;
              nxt_state = ST_WR;
            end
          end
        end
        ST_WR: begin
          if (scl_rise) begin
            nxt_shift = {shift_ff[6:0], sda_s};
            nxt_cnt = cnt_ff + 4'h1;
          end else if (scl_fall && cnt_ff == BITS_PER_BYTE) begin
            // Byte for register 1 and the read-only ones are acknowledged and dropped
            wr_ctrl = (ptr_ff == REG_CTRL); // see R21
            nxt_ptr = ptr_inc; // see R11
            nxt_sda_oe = 1'b1;
            nxt_cnt = 4'h0;
            nxt_state = ST_WACK;
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            nxt_sda_oe = 1'b0;
            nxt_state = ST_WR;
          end
        end
        ST_RD: begin
          if (scl_rise) begin
            nxt_cnt = cnt_ff + 4'h1;
          end else if (scl_fall) begin
            if (cnt_ff == BITS_PER_BYTE) begin
              nxt_sda_oe = 1'b0;
              nxt_cnt = 4'h0;
              nxt_state = ST_RACK;
            end else begin
              nxt_shift = {shift_ff[6:0], 1'b0};
              nxt_sda_oe = ~shift_ff[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            nxt_nack = sda_s;
          end else if (scl_fall) begin
            if (nack_ff) begin
              nxt_state = ST_IDLE;
            end else begin
              rd_load = 1'b1;
              nxt_shift = rd_data;
              nxt_sda_oe = ~rd_data[7];
              nxt_ptr = ptr_inc; // see R11
              nxt_state = ST_RD;
            end
          end
        end
        default: begin
          nxt_state = ST_IDLE;
          nxt_sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      ptr_ff <= REG_FIRST;
      rw_ff <= 1'b0;
      nack_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      ptr_ff <= nxt_ptr;
      rw_ff <= nxt_rw;
      nack_ff <= nxt_nack;
      sda_oe_ff <= nxt_sda_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control and interrupt registers

  // Strap: ground gives sink, supply gives source, open gives dual role with Try.SNK
  wire [1:0] strap_role = !port_tied_s ? ROLE_DRP_TRY :
                          port_high_s ? ROLE_SOURCE : ROLE_SINK; // see R10
  wire strap_try_snk = ~port_tied_s; // see R10
  wire strap_load = ~dis_s & ~en_seen_ff; // see R9

  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (strap_load) begin
      nxt_ctrl[CTRL_ROLE_HI:CTRL_ROLE_LO] = strap_role; // see R9
      nxt_ctrl[CTRL_TRY_SNK] = strap_try_snk; // see R10
    end else if (wr_ctrl) begin
      nxt_ctrl = shift_ff;
    end
  end

  // A new event in the clearing read cycle survives the clear
  wire [7:0] int_set = (ATTACH_EVT ? INT_ATTACH : 8'h00) | (DETACH_EVT ? INT_DETACH : 8'h00); // see R20
  wire int_clr = rd_load & (ptr_ff == REG_INT); // see R16
  assign nxt_int = (int_clr ? INT_RST : int_ff) | int_set; // see R15

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ctrl_ff <= CTRL_RST; // see R9
      int_ff <= INT_RST;
      en_seen_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      int_ff <= nxt_int;
      en_seen_ff <= en_seen_ff | ~dis_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  // The disable pin and the power-saving bit both enter the low-power state
  wire low_power = ctrl_ff[CTRL_PSAVE] | dis_s; // see R1
  wire [1:0] role = ctrl_ff[CTRL_ROLE_HI:CTRL_ROLE_LO]; // see R7
  wire sink_now = (role == ROLE_SINK) | ((role[1] == 1'b1) & ACTING_SINK);
  wire [1:0] cur = sink_now ? CUR_DEFAULT : ctrl_ff[CTRL_CUR_HI:CTRL_CUR_LO]; // see R5, see R6
  // Interrupt stays high-Z when masked or in low power
  wire irq_drive = (|int_ff) & ~ctrl_ff[CTRL_MASK] & ~low_power; // see R8, see R12, see R2

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      SDA_OUT <= 1'b0;
      SDA_OE <= 1'b0;
      IRQ_OUT_N_O <= 1'b0;
      IRQ_OUT_N_OE <= 1'b0;
      LOW_POWER <= 1'b0;
      PIN_MODE <= 1'b0;
      TRY_SNK <= 1'b0;
      ACC_DET_EN <= 1'b0;
      CHG_CUR <= CUR_DEFAULT;
      PORT_ROLE <= ROLE_SINK;
    end else begin
      SDA_OUT <= 1'b0;
      SDA_OE <= sda_oe_ff & bus_on; // see R19
      IRQ_OUT_N_O <= 1'b0;
      IRQ_OUT_N_OE <= irq_drive; // see R8
      LOW_POWER <= low_power; // see R1, see R2
      PIN_MODE <= ~bus_on; // see R19
      TRY_SNK <= ctrl_ff[CTRL_TRY_SNK]; // see R3
      ACC_DET_EN <= ctrl_ff[CTRL_ACC]; // see R4
      CHG_CUR <= cur;
      PORT_ROLE <= role;
    end
  end

endmodule

//--- core/tcp_sync.sv
`timescale 1ns/1ps
module tcp_sync import tcp_pkg::*; #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // The first stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;

endmodule

//--- verification/tcp_host_model.sv
`timescale 1ns/1ps
module tcp_host_model (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda
);
  // Clock stands high between frames; one bit is 160 ns
  initial begin
    scl = 1'h1;
    sda = 1'h1;
  end
  task automatic q();
    repeat (4) @(negedge clk);
  endtask
  task automatic start();
    sda = 1'h1; q(); scl = 1'h1; q(); sda = 1'h0; q(); scl = 1'h0; q();
  endtask
  task automatic stop();
    sda = 1'h0; q(); scl = 1'h1; q(); sda = 1'h1; q();
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda = b; q(); scl = 1'h1; q(); r = sda_line; q(); scl = 1'h0; q();
  endtask
  task automatic put_byte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'h1, r);
    ack = ~r;
  endtask
  // Last byte gets a NACK so the device lets go of the line
  task automatic get_byte(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'h1, r);
      v[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule

//--- verification/tcp_port_ctrl_monitor.sv
`timescale 1ns/1ps
module tcp_port_ctrl_monitor import tcp_pkg::*; (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic SCL_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic ACTING_SINK,
  input wire logic IRQ_OUT_N_O,
  input wire logic IRQ_OUT_N_OE,
  input wire logic LOW_POWER,
  input wire logic PIN_MODE,
  input wire logic [1:0] CHG_CUR,
  input wire logic [1:0] PORT_ROLE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // Two cycles so the interrupt pin has seen the same low-power source
  sequence s_lp_settled;
    LOW_POWER ##1 LOW_POWER;
  endsequence
  a_lp_irq_quiet: assert property (s_lp_settled |-> !IRQ_OUT_N_OE)
    else $error("interrupt driven in low power");
  a_irq_rise_awake: assert property ($rose(IRQ_OUT_N_OE) |-> !LOW_POWER)
    else $error("interrupt raised while asleep");
  a_irq_open_drain: assert property (IRQ_OUT_N_O == 1'h0)
    else $error("interrupt pin driven high");
  a_sda_open_drain: assert property (SDA_OUT == 1'h0)
    else $error("data pin driven high");
  a_sink_no_current: assert property (PORT_ROLE == ROLE_SINK |-> CHG_CUR == CUR_DEFAULT)
    else $error("current advertised as sink");
  a_acting_no_current: assert property (PORT_ROLE[1] && $past(ACTING_SINK) |-> CHG_CUR == CUR_DEFAULT)
    else $error("current advertised while acting as device");
  a_pin_mode_silent: assert property (PIN_MODE |-> !SDA_OE)
    else $error("bus answered in pin mode");
  a_sda_scl_low: assert property ($changed(SDA_OE) |-> !SCL_IN)
    else $error("data changed while bus clock high");
endmodule

bind tcp_port_ctrl tcp_port_ctrl_monitor u_mon (
  .REF_CLK(REF_CLK), .RST(RST), .SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
  .ACTING_SINK(ACTING_SINK), .IRQ_OUT_N_O(IRQ_OUT_N_O), .IRQ_OUT_N_OE(IRQ_OUT_N_OE),
  .LOW_POWER(LOW_POWER), .PIN_MODE(PIN_MODE), .CHG_CUR(CHG_CUR), .PORT_ROLE(PORT_ROLE));

//--- verification/testbench.sv
`timescale 1ns/1ps
module testbench import tcp_pkg::*;;
  logic REF_CLK, RST, DISABLE_IN, ADDR_TIED, ADDR_HIGH, PORT_TIED, PORT_HIGH;
  logic ATTACH_EVT, DETACH_EVT, ACTING_SINK, SDA_OUT, SDA_OE, IRQ_OUT_N_O, IRQ_OUT_N_OE;
  logic LOW_POWER, PIN_MODE, TRY_SNK, ACC_DET_EN, scl, host_sda;
  logic [1:0] CHG_CUR, PORT_ROLE;
  logic [7:0] CC_STATUS, m_ctrl, m_int;
  logic [31:0] seed = 32'hCFAF;
  int errors = 0;
  int n_tests = 0;
  // Pull-up on the data line
  wire sda_line = host_sda & ~SDA_OE;
  tcp_port_ctrl dut (.REF_CLK(REF_CLK), .RST(RST), .SCL_IN(scl), .SDA_IN(sda_line), .SDA_OUT(SDA_OUT),
    .SDA_OE(SDA_OE), .DISABLE_IN(DISABLE_IN), .ADDR_TIED(ADDR_TIED), .ADDR_HIGH(ADDR_HIGH),
    .PORT_TIED(PORT_TIED), .PORT_HIGH(PORT_HIGH), .ATTACH_EVT(ATTACH_EVT), .DETACH_EVT(DETACH_EVT),
    .ACTING_SINK(ACTING_SINK), .CC_STATUS(CC_STATUS), .IRQ_OUT_N_O(IRQ_OUT_N_O), .IRQ_OUT_N_OE(IRQ_OUT_N_OE),
    .LOW_POWER(LOW_POWER), .PIN_MODE(PIN_MODE), .TRY_SNK(TRY_SNK), .ACC_DET_EN(ACC_DET_EN),
    .CHG_CUR(CHG_CUR), .PORT_ROLE(PORT_ROLE));
  tcp_host_model host (.clk(REF_CLK), .sda_line(sda_line), .scl(scl), .sda(host_sda));
  initial begin
    REF_CLK = 1'h0;
    forever #5 REF_CLK = ~REF_CLK;
  end
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_outs();
    logic lp;
    logic [1:0] cur;
    lp = m_ctrl[CTRL_PSAVE] | DISABLE_IN;
    cur = (m_ctrl[2:1] == ROLE_SINK || (m_ctrl[2] && ACTING_SINK)) ? CUR_DEFAULT : m_ctrl[4:3];
    repeat (4) @(negedge REF_CLK);
    cmp_byte({LOW_POWER, TRY_SNK, ACC_DET_EN, CHG_CUR, PORT_ROLE, IRQ_OUT_N_OE},
      {lp, m_ctrl[6:5], cur, m_ctrl[2:1], (m_int != 8'h00) & ~m_ctrl[CTRL_MASK] & ~lp});
  endtask
  task automatic wr_ctrl(input logic [7:0] v);
    logic a0, a1, a2;
    logic [7:0] junk;
    junk = rnd();
    host.start();
    host.put_byte({BUS_ADDR_LOW, 1'h0}, a0);
    host.put_byte(junk, a1);
    host.put_byte(v, a2);
    host.stop();
    m_ctrl = v;
    cmp_bit(a0 & a1 & a2, 1'h1);
  endtask
  task automatic rd_all();
    logic a;
    logic [7:0] b [4];
    CC_STATUS = rnd();
    host.start();
    host.put_byte({BUS_ADDR_LOW, 1'h1}, a);
    for (int i = 0; i < 4; i++) host.get_byte(i == 3, b[i]);
    host.stop();
    cmp_bit(a, 1'h1);
    cmp_byte(b[0], 8'h00);
    cmp_byte(b[1], m_ctrl);
    cmp_byte(b[2], m_int);
    cmp_byte(b[3], CC_STATUS);
    m_int = INT_RST;
  endtask
  task automatic probe(input logic [6:0] a, input logic exp);
    logic k;
    host.start();
    host.put_byte({a, 1'h0}, k);
    host.stop();
    cmp_bit(k, exp);
  endtask
  task automatic pulse(input logic det);
    if (det) DETACH_EVT = 1'h1;
    else ATTACH_EVT = 1'h1;
    m_int = m_int | (det ? INT_DETACH : INT_ATTACH);
    @(negedge REF_CLK);
    ATTACH_EVT = 1'h0;
    DETACH_EVT = 1'h0;
  endtask
  task automatic end_of_test();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  logic [7:0] codes [10] = '{8'h46, 8'h0A, 8'h12, 8'h16, 8'h14, 8'h0C, 8'h20, 8'h02, 8'h81, 8'h04};
  initial begin
    logic [7:0] r;
    DISABLE_IN = 1'h0;
    ADDR_TIED = 1'h1;
    ADDR_HIGH = 1'h0;
    ATTACH_EVT = 1'h0;
    DETACH_EVT = 1'h0;
    ACTING_SINK = 1'h0;
    CC_STATUS = 8'h00;
    // Each strap setting needs a fresh reset: the role loads only once
    for (int k = 0; k < 3; k++) begin
      RST = 1'h1;
      PORT_TIED = k != 2;
      PORT_HIGH = k == 1;
      repeat (10) @(negedge REF_CLK);
      RST = 1'h0;
      repeat (6) @(negedge REF_CLK);
      m_int = INT_RST;
      m_ctrl = (k == 0) ? CTRL_RST : (k == 1) ? 8'h02 : 8'h46;
      chk_outs();
      rd_all();
    end
    foreach (codes[i]) begin
      r = rnd();
      ACTING_SINK = r[0];
      wr_ctrl(codes[i]);
      chk_outs();
    end
    pulse(1'h0);
    chk_outs();
    wr_ctrl(8'h05);
    chk_outs();
    rd_all();
    chk_outs();
    rd_all();
    wr_ctrl(8'h04);
    pulse(1'h1);
    chk_outs();
    DISABLE_IN = 1'h1;
    chk_outs();
    rd_all();
    DISABLE_IN = 1'h0;
    chk_outs();
    for (int j = 0; j < 3; j++) begin
      ADDR_TIED = j != 2;
      ADDR_HIGH = j == 1;
      repeat (4) @(negedge REF_CLK);
      cmp_bit(PIN_MODE, j == 2);
      probe(BUS_ADDR_LOW, j == 0);
      probe(BUS_ADDR_HIGH, j == 1);
    end
    end_of_test();
  end
  // Whole run is near 11000 cycles
  initial begin
    repeat (80000) @(posedge REF_CLK);
    errors++;
    end_of_test();
  end
endmodule
